/* File: ofpe_pkg.sv */
// Purpose: Shared constants and types for the on-chip flash program/erase controller.
// Assumes: One clock, clk, at 40 MHz; the flash interface clock is derived by division.
// Notes:   Read wait counts are derived from the clock rate, never hand-entered.
package ofpe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and read timing
  localparam int CLK_PERIOD_NS       = 25;
  localparam int CLK_FREQ_MHZ        = 1000 / CLK_PERIOD_NS;
  localparam int CF_FAST_LIMIT_MHZ   = 32;
  localparam int CF_HIT_CYCLES       = 1;
  localparam int CF_MISS_CYCLES_FAST = 2;
  localparam int CF_MISS_CYCLES_SLOW = 1;
  localparam int CF_MISS_WAIT        = (CLK_FREQ_MHZ > CF_FAST_LIMIT_MHZ) ?
                                       CF_MISS_CYCLES_FAST : CF_MISS_CYCLES_SLOW;
  // Flash interface clock is clk divided down to stay at or below its limit
  localparam int FLASH_INTERFACE_CLOCK_MAX_MHZ        = 32;
  localparam int FLASH_INTERFACE_CLOCK_DIV            = (CLK_FREQ_MHZ + FLASH_INTERFACE_CLOCK_MAX_MHZ - 1) / FLASH_INTERFACE_CLOCK_MAX_MHZ;
  localparam int DF_READ_FLASH_INTERFACE_CLOCK        = 6;
  localparam int DF_READ_CYCLES      = DF_READ_FLASH_INTERFACE_CLOCK * FLASH_INTERFACE_CLOCK_DIV;
  localparam int WAIT_CNT_W          = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Areas, words and erase/program granularity
  localparam int CF_ADDR_W    = 18;
  localparam int DF_ADDR_W    = 13;
  localparam int CF_WORD_W    = 64;
  localparam int DF_WORD_W    = 8;
  localparam int CF_PROG_LSB  = 3;
  localparam int CF_ERASE_LSB = 11;
  localparam int DF_ERASE_LSB = 10;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states and controller state
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RUN  = 3'b010,
    SEQ_DONE = 3'b100
  } ofpe_seq_e;
  localparam ofpe_seq_e SEQ_RESET = SEQ_IDLE;

  typedef struct packed {
    ofpe_seq_e              seq;
    logic                   opCode;
    logic                   opErase;
    logic [CF_ADDR_W-1:0]   opAddr;
    logic [CF_WORD_W-1:0]   opData;
    logic                   cmdErr;
    logic                   opDone;
    logic                   cfPend;
    logic [CF_ADDR_W-1:0]   cfAddrQ;
    logic                   cfAck;
    logic [CF_WORD_W-1:0]   cfRdata;
    logic                   cfErased;
    logic                   dfPend;
    logic [DF_ADDR_W-1:0]   dfAddrQ;
    logic                   dfAck;
    logic [DF_WORD_W-1:0]   dfRdata;
  } ofpe_ctrl_s;

endpackage

/* File: ofpe_wait_cnt.sv */
// Purpose: Loadable down-counter that flags the last cycle of a read wait.
// Assumes: Load values of one or more; a load of zero wraps and expires as a load of 2**CNT_W would.
// Notes:   Expire is combinational so the caller can capture data on that edge.
`timescale 1ns/100ps
module ofpe_wait_cnt
  import ofpe_pkg::*;
#(
  parameter int CNT_W = WAIT_CNT_W
)(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] loadVal,
  output logic                  expire
);

  typedef struct packed {
    logic             active;
    logic [CNT_W-1:0] cnt;
  } ofpe_cnt_s;

  ofpe_cnt_s q;
  ofpe_cnt_s next_q;

  ////////////////////////////////////////////////////////////////////////////
  // Last counted cycle
  assign expire = q.active && (q.cnt == CNT_W'(1));

  // Count down; a fresh load wins over the running count
  always_comb
  begin
    next_q = q;
    if (load)
    begin
      next_q.active = 1'b1;
      next_q.cnt    = loadVal;
    end
    else if (q.active)
    begin
      next_q.cnt = q.cnt - CNT_W'(1);
      if (q.cnt == CNT_W'(1))
        next_q.active = 1'b0;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk)
  begin
    if (srst)
      q <= '0;
    else if (ce)
      q <= next_q;
  end

endmodule

/* File: ofpe_align_chk.sv */
// Purpose: Checks that an address sits on a program or erase unit boundary.
// Assumes: LSB of one or more, the unit being 2**LSB bytes.
// Notes:   Pure logic; holds no state.
`timescale 1ns/100ps
module ofpe_align_chk
  import ofpe_pkg::*;
#(
  parameter int ADDR_W = CF_ADDR_W,
  parameter int LSB    = CF_PROG_LSB
)(
  input  wire logic [ADDR_W-1:0] addr,
  output logic                   aligned
);

  ////////////////////////////////////////////////////////////////////////////
  // Low bits must be clear
  assign aligned = (addr[LSB-1:0] == '0);

endmodule

/* File: ofpe_ctrl.sv */
// Purpose: On-chip flash controller: paced code/data reads and program/erase sequencing.
// Assumes: Flash macro outside reads combinationally and reports fmDone on clk.
// Notes:   Requests and the macro share clk, so no input needs synchronising.
//
// Functional notes
// - Code flash: 64-bit program, 2 KB erase.
// - Data flash: byte program, 1 KB erase.
// - Code read: hit one cycle, miss clock-dependent.
// - Data byte read takes six flash-clock cycles.
// - Erased code reads FFh; data undefined.
// - Code reads continue during data operation.
// - Data flash closed during code operation.
// - Non-flash memory stays usable during operations.
// - Interrupts keep running during self-programming.
// - Commands from command block start sequencer.
// - Self-programming needs no system reset.
`timescale 1ns/100ps
module ofpe_ctrl
  import ofpe_pkg::*;
#(
  parameter int CF_MISS_WAIT_P   = CF_MISS_WAIT,
  parameter int DF_READ_CYCLES_P = DF_READ_CYCLES
)(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 ce,
  input  wire logic                 cfReq,
  input  wire logic [CF_ADDR_W-1:0] cfAddr,
  input  wire logic                 cfHit,
  output logic                      cfReady,
  output logic                      cfAck,
  output logic [CF_WORD_W-1:0]      cfRdata,
  output logic                      cfErased,
  input  wire logic                 dfReq,
  input  wire logic [DF_ADDR_W-1:0] dfAddr,
  output logic                      dfReady,
  output logic                      dfAck,
  output logic [DF_WORD_W-1:0]      dfRdata,
  input  wire logic                 cmdValid,
  input  wire logic                 cmdCode,
  input  wire logic                 cmdErase,
  input  wire logic [CF_ADDR_W-1:0] cmdAddr,
  input  wire logic [CF_WORD_W-1:0] cmdData,
  output logic                      cmdReady,
  output logic                      cmdErr,
  output logic                      opDone,
  output logic                      busy,
  output logic                      coreStall,
  output logic [CF_ADDR_W-1:0]      cfArrAddr,
  input  wire logic [CF_WORD_W-1:0] cfArrData,
  output logic [DF_ADDR_W-1:0]      dfArrAddr,
  input  wire logic [DF_WORD_W-1:0] dfArrData,
  output logic                      fmProg,
  output logic                      fmErase,
  output logic                      fmCode,
  output logic [CF_ADDR_W-1:0]      fmAddr,
  output logic [CF_WORD_W-1:0]      fmWdata,
  input  wire logic                 fmDone
);

  localparam logic [WAIT_CNT_W-1:0] CF_MISS_LOAD = WAIT_CNT_W'(CF_MISS_WAIT_P - 1);
  localparam logic [WAIT_CNT_W-1:0] DF_READ_LOAD = WAIT_CNT_W'(DF_READ_CYCLES_P - 1);
  localparam logic [CF_WORD_W-1:0]  CF_ERASED_WORD = {(CF_WORD_W / 8){ERASED_BYTE}};
  localparam logic [CF_WORD_W-DF_WORD_W-1:0] DF_PAD = '0;
  localparam logic [CF_ADDR_W-DF_ADDR_W-1:0] DF_HIGH_ZERO = '0;

  ofpe_ctrl_s q;
  ofpe_ctrl_s next_q;

  logic codeBusy;
  logic dataBusy;
  logic cfQuick;
  logic cfTake;
  logic dfTake;
  logic cmdTake;
  logic cfExpire;
  logic dfExpire;
  logic cfProgOk;
  logic cfEraseOk;
  logic dfEraseOk;
  logic dfInRange;
  logic alignOk;

  ////////////////////////////////////////////////////////////////////////////
  // Unit boundary checks on the command address
  // code and data unit alignment
  ofpe_align_chk #(.ADDR_W(CF_ADDR_W), .LSB(CF_PROG_LSB)) uCfProg (
    .addr    (cmdAddr),
    .aligned (cfProgOk)
  );
  ofpe_align_chk #(.ADDR_W(CF_ADDR_W), .LSB(CF_ERASE_LSB)) uCfErase (
    .addr    (cmdAddr),
    .aligned (cfEraseOk)
  );
  ofpe_align_chk #(.ADDR_W(CF_ADDR_W), .LSB(DF_ERASE_LSB)) uDfErase (
    .addr    (cmdAddr),
    .aligned (dfEraseOk)
  );

  // Data area commands must not address beyond the data area; bytes need no alignment
  assign dfInRange = (cmdAddr[CF_ADDR_W-1:DF_ADDR_W] == DF_HIGH_ZERO);
  assign alignOk   = cmdCode ? (cmdErase ? cfEraseOk : cfProgOk)
                             : (dfInRange && (!cmdErase || dfEraseOk));

  ////////////////////////////////////////////////////////////////////////////
  // Read wait counters
  ofpe_wait_cnt #(.CNT_W(WAIT_CNT_W)) uCfWait (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .load    (cfTake && !cfQuick),
    .loadVal (CF_MISS_LOAD),
    .expire  (cfExpire)
  );
  ofpe_wait_cnt #(.CNT_W(WAIT_CNT_W)) uDfWait (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .load    (dfTake),
    .loadVal (DF_READ_LOAD),
    .expire  (dfExpire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration between reads and the program/erase sequencer
  assign busy     = (q.seq != SEQ_IDLE);
  assign codeBusy = busy && q.opCode;
  assign dataBusy = busy && !q.opCode;
  // slow clock makes a miss as quick as a hit
  assign cfQuick  = cfHit || (CF_MISS_WAIT_P == 1);
  // Commands wait until no read is in flight, so no read sees half-changed cells
  assign cmdReady = (q.seq == SEQ_IDLE) && !q.cfPend && !q.dfPend;
  assign cmdTake  = ce && cmdValid && cmdReady;
  // code reads only blocked by code operations
  assign cfReady  = !q.cfPend && !codeBusy && !(cmdTake && cmdCode);
  // data flash closed while any operation runs
  assign dfReady  = !q.dfPend && !busy && !cmdTake;
  assign cfTake   = ce && cfReq && cfReady;
  assign dfTake   = ce && dfReq && dfReady;
  // stall only a waiting flash access
  // core and interrupts otherwise run freely
  assign coreStall = q.cfPend || q.dfPend || (cfReq && !cfReady) || (dfReq && !dfReady);

  // Macro read addresses hold steady while a read waits
  assign cfArrAddr = q.cfPend ? q.cfAddrQ : cfAddr;
  assign dfArrAddr = q.dfAddrQ;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the flash macro and the requesters
  // sequencer drives the macro
  assign fmProg   = (q.seq == SEQ_RUN) && !q.opErase;
  assign fmErase  = (q.seq == SEQ_RUN) && q.opErase;
  assign fmCode   = q.opCode;
  assign fmAddr   = q.opAddr;
  assign fmWdata  = q.opData;
  assign cfAck    = q.cfAck;
  assign cfRdata  = q.cfRdata;
  assign cfErased = q.cfErased;
  assign dfAck    = q.dfAck;
  assign dfRdata  = q.dfRdata;
  assign cmdErr   = q.cmdErr;
  assign opDone   = q.opDone;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_q        = q;
    next_q.cfAck  = 1'b0;
    next_q.dfAck  = 1'b0;
    next_q.cmdErr = 1'b0;
    next_q.opDone = 1'b0;
    // hit answers next cycle, miss after wait
    if (cfTake && cfQuick)
    begin
      next_q.cfAck    = 1'b1;
      next_q.cfRdata  = cfArrData;
      next_q.cfErased = (cfArrData == CF_ERASED_WORD);
    end
    else if (cfTake)
    begin
      next_q.cfPend  = 1'b1;
      next_q.cfAddrQ = cfAddr;
    end
    if (cfExpire)
    begin
      next_q.cfPend   = 1'b0;
      next_q.cfAck    = 1'b1;
      next_q.cfRdata  = cfArrData;
      next_q.cfErased = (cfArrData == CF_ERASED_WORD);
    end
    // data read paced in flash-clock cycles
    if (dfTake)
    begin
      next_q.dfPend  = 1'b1;
      next_q.dfAddrQ = dfAddr;
    end
    if (dfExpire)
    begin
      next_q.dfPend  = 1'b0;
      next_q.dfAck   = 1'b1;
      next_q.dfRdata = dfArrData;
    end
    unique case (q.seq)
      SEQ_IDLE:
      begin
        if (cmdTake && !alignOk)
          next_q.cmdErr = 1'b1;
        else if (cmdTake)
        begin
          next_q.seq     = SEQ_RUN;
          next_q.opCode  = cmdCode;
          next_q.opErase = cmdErase;
          next_q.opAddr  = cmdAddr;
          next_q.opData  = cmdCode ? cmdData : {DF_PAD, cmdData[DF_WORD_W-1:0]};
        end
      end
      SEQ_RUN:
      begin
        if (fmDone)
          next_q.seq = SEQ_DONE;
      end
      SEQ_DONE:
      begin
        next_q.seq    = SEQ_IDLE;
        next_q.opDone = 1'b1;
      end
      default:
        next_q.seq = SEQ_IDLE;
    endcase
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q     <= '0;
      q.seq <= SEQ_RESET;
    end
    else if (ce)
      q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int ACfMiss = CF_MISS_WAIT_P;
  localparam int ADfRead = DF_READ_CYCLES_P;

  default clocking cbk @(posedge clk); endclocking
  default disable iff (srst || !ce);

  a_cf_prog_align: assert property (
    fmProg && fmCode |-> fmAddr[CF_PROG_LSB-1:0] == '0)
    else $error("Code program not on 64-bit unit");
  a_cf_erase_align: assert property (
    fmErase && fmCode |-> fmAddr[CF_ERASE_LSB-1:0] == '0)
    else $error("Code erase not on 2 KB block");
  a_df_unit_size: assert property (
    (fmProg || fmErase) && !fmCode |->
      fmWdata[CF_WORD_W-1:DF_WORD_W] == '0 &&
      (!fmErase || fmAddr[DF_ERASE_LSB-1:0] == '0))
    else $error("Data operation outside byte or 1 KB unit");
  a_cf_hit_one: assert property (
    cfTake && cfHit |=> cfAck)
    else $error("Code hit not answered in one cycle");
  a_cf_miss_wait: assert property (
    cfTake && !cfQuick |=> !cfAck ##(ACfMiss - 1) cfAck)
    else $error("Code miss wait wrong");
  a_df_read_wait: assert property (
    dfTake |=> !dfAck [*2] ##(ADfRead - 2) dfAck)
    else $error("Data read not paced by six flash cycles");
  a_cf_erased_flag: assert property (
    cfAck |-> cfErased == (cfRdata == CF_ERASED_WORD))
    else $error("Erased flag disagrees with data");
  a_cf_bg_read: assert property (
    dataBusy && !q.cfPend |-> cfReady)
    else $error("Code read refused during data operation");
  a_df_closed: assert property (
    codeBusy |-> !dfReady && !dfAck)
    else $error("Data flash open during code operation");
  a_core_free: assert property (
    busy && !cfReq && !dfReq && !q.cfPend && !q.dfPend |-> !coreStall)
    else $error("Core stalled with no flash access");
  a_cmd_start: assert property (
    cmdTake && alignOk |=> (fmProg || fmErase) && busy)
    else $error("Accepted command did not start sequencer");
  a_op_release: assert property (
    fmDone && q.seq == SEQ_RUN |=> busy ##1 (opDone && !busy && (cfReady || q.cfPend)))
    else $error("Controller not free after operation");
  a_busy_stall: assert property (
    codeBusy && cfReq |-> !cfReady && coreStall && !cfTake)
    else $error("Code access not stalled during code operation");

  c_cf_hit:   cover property (cfTake && cfHit ##1 cfAck);
  c_cf_miss:  cover property (cfTake && !cfQuick ##ACfMiss cfAck);
  c_df_read:  cover property (dfTake ##ADfRead dfAck);
  c_bg_read:  cover property (dataBusy && cfTake);
  c_op_done:  cover property (fmDone ##2 opDone);

endmodule

/* File: ofpe_flash_model.sv */
// Purpose: Behavioural flash array and program/erase macro facing the controller.
// Assumes: Array content is fixed; program and erase only consume time.
// Notes:   Code addresses with bits 17:16 set read as erased.
`timescale 1ns/100ps
module ofpe_flash_model
  import ofpe_pkg::*;
(
  input  wire logic [CF_ADDR_W-1:0] cfArrAddr,
  output logic      [CF_WORD_W-1:0] cfArrData,
  input  wire logic [DF_ADDR_W-1:0] dfArrAddr,
  output logic      [DF_WORD_W-1:0] dfArrData,
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 fmProg,
  input  wire logic                 fmErase,
  input  wire logic [7:0]           doneDelay,
  output logic                      fmDone
);
  logic [7:0] opCnt;

  ////////////////////////////////////////////////////////////////////////////
  // erased code reads ones
  // Reads are combinational, since the controller samples data in the same cycle
  always_comb
  begin
    cfArrData = (cfArrAddr[17:16] == 2'h3) ? {CF_WORD_W{1'b1}} : {4{cfArrAddr[15:0] ^ 16'ha5c3}};
    dfArrData = dfArrAddr[7:0] ^ 8'h3c;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer completion timing
  // The bench picks prompt or slow completion through doneDelay
  always_ff @(posedge clk)
  begin
    if (srst || !(fmProg || fmErase))
      opCnt <= 8'h00;
    else
      opCnt <= opCnt + 8'h01;
  end
  assign fmDone = (fmProg || fmErase) && (opCnt == doneDelay);
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the flash program/erase controller.
// Assumes: Inputs change 2 ns after each rising edge; ce drops once to test the freeze.
// Notes:   Expected data comes from bench functions, not from the model.
`timescale 1ns/100ps
module testbench;
  import ofpe_pkg::*;
  localparam int PER = 25;
  localparam int DLY = 2;
  localparam logic [17:0] BAD [4] = '{18'h02000, 18'h00200, 18'h00004, 18'h00400};
  localparam logic [17:0] MSK [4] = '{18'h01fff, 18'h01c00, 18'h3fff8, 18'h3f800};
  logic                 clk, srst, ce, cfReq, cfHit, dfReq, cmdValid, cmdCode, cmdErase;
  logic [CF_ADDR_W-1:0] cfAddr, cmdAddr, cfArrAddr, fmAddr;
  logic [DF_ADDR_W-1:0] dfAddr, dfArrAddr;
  logic [CF_WORD_W-1:0] cmdData, cfRdata, cfArrData, fmWdata;
  logic [DF_WORD_W-1:0] dfRdata, dfArrData;
  logic                 cfReady, cfAck, cfErased, dfReady, dfAck, cmdReady, cmdErr;
  logic                 opDone, busy, coreStall, fmProg, fmErase, fmCode, fmDone;
  logic [7:0]           doneDelay;
  int                   errors, totalChecks, doneCnt;

  ofpe_ctrl i_dut (.clk(clk), .srst(srst), .ce(ce), .cfReq(cfReq), .cfAddr(cfAddr),
    .cfHit(cfHit), .cfReady(cfReady), .cfAck(cfAck), .cfRdata(cfRdata), .cfErased(cfErased),
    .dfReq(dfReq), .dfAddr(dfAddr), .dfReady(dfReady), .dfAck(dfAck), .dfRdata(dfRdata),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdErase(cmdErase), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdReady(cmdReady), .cmdErr(cmdErr), .opDone(opDone), .busy(busy),
    .coreStall(coreStall), .cfArrAddr(cfArrAddr), .cfArrData(cfArrData),
    .dfArrAddr(dfArrAddr), .dfArrData(dfArrData), .fmProg(fmProg), .fmErase(fmErase),
    .fmCode(fmCode), .fmAddr(fmAddr), .fmWdata(fmWdata), .fmDone(fmDone));

  ofpe_flash_model i_model (.cfArrAddr(cfArrAddr), .cfArrData(cfArrData),
    .dfArrAddr(dfArrAddr), .dfArrData(dfArrData), .clk(clk), .srst(srst),
    .fmProg(fmProg), .fmErase(fmErase), .doneDelay(doneDelay), .fmDone(fmDone));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, completion monitor and watchdog
  always #(PER / 2.0) clk = ~clk;

  always @(negedge clk)
  begin
    if (opDone === 1'b1)
    begin
      doneCnt++;
      check("busyAtDone", busy, 1'b0);
    end
  end

  initial
  begin
    #(PER * 20000);
    errors++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks and expectations
  function automatic logic [63:0] cf_exp(input logic [17:0] a);
    return (a[17:16] == 2'h3) ? {64{1'b1}} : {4{a[15:0] ^ 16'ha5c3}};
  endfunction

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #DLY;
  endtask

  // A stalled request must wait, not return stale data, so st expects a stall
  task automatic code_read(input logic [17:0] a, input logic h, input logic st);
    int n;
    cfReq = 1'b1;
    cfAddr = a;
    cfHit = h;
    #1;
    if (st)
      check("coreStall", coreStall, 1'b1);
    n = 0;
    while (cfReady !== 1'b1 && n < 300)
    begin
      step();
      n++;
    end
    step();
    cfReq = 1'b0;
    cfHit = 1'b0;
    n = 1;
    while (cfAck !== 1'b1 && n < 300)
    begin
      step();
      n++;
    end
    check("cfLatency", n, h ? CF_HIT_CYCLES : CF_MISS_WAIT);
    check("cfRdata", cfRdata, cf_exp(a));
    check("cfErased", cfErased, &cf_exp(a));
    step(); // Back-to-back calls never rewrite cfReq in one time step
  endtask

  task automatic data_read(input logic [12:0] a);
    int n;
    dfReq = 1'b1;
    dfAddr = a;
    n = 0;
    while (dfReady !== 1'b1 && n < 300)
    begin
      step();
      n++;
    end
    step();
    dfReq = 1'b0;
    n = 1;
    while (dfAck !== 1'b1 && n < 300)
    begin
      step();
      n++;
    end
    check("dfLatency", n, DF_READ_CYCLES);
    check("dfRdata", dfRdata, a[7:0] ^ 8'h3c);
  endtask

  task automatic command(input logic c, input logic e, input logic [17:0] a,
                         input logic [63:0] d, input logic bad);
    int n;
    int d0;
    d0 = doneCnt;
    cmdValid = 1'b1;
    cmdCode = c;
    cmdErase = e;
    cmdAddr = a;
    cmdData = d;
    n = 0;
    while (cmdReady !== 1'b1 && n < 300)
    begin
      step();
      n++;
    end
    step();
    cmdValid = 1'b0;
    check("cmdErr", cmdErr, bad);
    if (bad)
    begin
      check("busyOnErr", busy, 1'b0);
      step();
    end
    else
    begin
      check("busy", busy, 1'b1);
      check("fmProg", fmProg, !e);
      check("fmErase", fmErase, e);
      check("fmCode", fmCode, c);
      check("fmAddr", fmAddr, a);
      check("fmWdata", fmWdata, c ? d : {56'h0, d[7:0]});
      check("dfReady", dfReady, 1'b0);
      if (c)
      begin
        check("cfReady", cfReady, 1'b0);
        code_read(18'($urandom) & 18'h0fff8, 1'b1, 1'b1);
      end
      else
      begin
        check("idleStall", coreStall, 1'b0);
        code_read(18'($urandom) & 18'h0fff8, 1'b1, 1'b0);
        check("busyInRead", busy, 1'b1);
      end
      n = 0;
      while (doneCnt == d0 && n < 300)
      begin
        step();
        n++;
      end
      check("opDoneCount", doneCnt, d0 + 1);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, corner cases, every command kind, then random reads
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    {cfReq, cfHit, dfReq, cmdValid, cmdCode, cmdErase} = '0;
    {cfAddr, dfAddr, cmdAddr, cmdData} = '0;
    doneDelay = 8'd3;
    errors = 0;
    totalChecks = 0;
    doneCnt = 0;
    void'($urandom(32'h8495b3e3));
    repeat (5) @(posedge clk);
    #DLY;
    srst = 1'b0;
    check("busyRst", busy, 1'b0);
    check("cmdReadyRst", cmdReady, 1'b1);
    check("stallRst", coreStall, 1'b0);
    step();
    code_read(18'h30008, 1'b1, 1'b0);
    code_read(18'h00010, 1'b1, 1'b0);
    code_read(18'h00018, 1'b0, 1'b0);
    data_read(13'h1fff);
    // Freeze: a data read taken just before ce drops must not advance while ce is low
    dfReq = 1'b1;
    dfAddr = 13'h0a5a;
    step();
    dfReq = 1'b0;
    ce = 1'b0;
    repeat (20) step();
    check("dfAckFrozen", dfAck, 1'b0);
    check("stallFrozen", coreStall, 1'b1);
    ce = 1'b1;
    repeat (DF_READ_CYCLES - 2) step();
    check("dfAckEarly", dfAck, 1'b0);
    step();
    check("dfAckThaw", dfAck, 1'b1);
    check("dfRdataThaw", dfRdata, 8'h5a ^ 8'h3c);
    for (int m = 0; m < 4; m++)
    begin
      doneDelay = 8'd40;
      command(m[1], m[0], 18'($urandom) & MSK[m], {$urandom, $urandom}, 1'b0);
      doneDelay = 8'd1 + 8'($urandom_range(0, 5));
      command(m[1], m[0], 18'($urandom) & MSK[m], {$urandom, $urandom}, 1'b0);
      command(m[1], m[0], BAD[m], 64'h0, 1'b1);
    end
    for (int i = 0; i < 20; i++)
    begin
      code_read(18'($urandom), 1'($urandom), 1'b0);
      data_read(13'($urandom));
    end
    close_out();
  end
endmodule
